// file: bench/tb_vlan_table_write_data.sv
// self-checking bench for the vlan write-data staging block
// assumes vtwd_top with default parameters and the bound checker
`timescale 1ns/100ps
`include "vtwd_consts.vh"

module tb_vlan_table_write_data;
	typedef struct packed {
		logic [31:0] wd;
		logic [5:0] cmd;
		logic [1:0] port;
		logic tg;
		logic [11:0] vid;
		logic [2:0] pri;
		logic [21:0] exp;
	} vtwd_row_t;
	logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic rx_valid = 0, rx_tagged = 0;
	logic [1:0] rx_port = 2'h0;
	logic [11:0] rx_vid = 12'h000;
	logic [2:0] rx_pri = 3'h0;
	wire [31:0] prdata;
	wire pready, pslverr, cls_valid, cls_drop;
	wire [11:0] cls_vid;
	wire [2:0] cls_pri, cls_egress, cls_untag;
	int bad_count = 0, total_checks = 0, cyc = 0;
	logic [31:0] rd;
	logic er;
	vtwd_row_t rows [7];

	vtwd_top dut (
		.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
		.rx_port(rx_port), .rx_tagged(rx_tagged), .rx_vid(rx_vid),
		.rx_pri(rx_pri), .cls_valid(cls_valid), .cls_drop(cls_drop),
		.cls_vid(cls_vid), .cls_pri(cls_pri), .cls_egress(cls_egress),
		.cls_untag(cls_untag)
	);

	initial begin
		forever #4 clock = ~clock;
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task summarize();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h want %h", $time, seen, exp);
		end
	endtask

	// holds the request until pready is sampled high
	task apb(input logic w, input logic [13:0] idx, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= {idx, 2'h0};
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		@(posedge clock);
		while (pready !== 1'h1)
			@(posedge clock);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task send(input logic [1:0] p, input logic t, input logic [11:0] v,
		input logic [2:0] pr);
		@(posedge clock);
		rx_valid <= 1'h1;
		rx_port <= p;
		rx_tagged <= t;
		rx_vid <= v;
		rx_pri <= pr;
		@(posedge clock);
		rx_valid <= 1'h0;
		#1;
		chk(cls_valid, 32'h0000_0001);
	endtask

	function logic [31:0] cls();
		return {10'h000, cls_drop, cls_vid, cls_pri, cls_egress, cls_untag};
	endfunction

	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			summarize();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rows[0] = '{32'h0003_200a, 6'h00, 2'h0, 1'h1, 12'h00a, 3'h5,
			{1'h0, 12'h00a, 3'h5, 3'h4, 3'h4}};
		rows[1] = '{32'h0003_200a, 6'h00, 2'h1, 1'h1, 12'h00a, 3'h5,
			{1'h1, 12'h00a, 3'h5, 3'h0, 3'h0}};
		rows[2] = '{32'h0002_c0fe, 6'h01, 2'h2, 1'h1, 12'h0fe, 3'h2,
			{1'h0, 12'h0fe, 3'h2, 3'h2, 3'h2}};
		rows[3] = '{32'h0002_b0fe, 6'h10, 2'h0, 1'h1, 12'h000, 3'h7,
			{1'h1, 12'h0fe, 3'h3, 3'h0, 3'h0}};
		rows[4] = '{32'h0003_e000, 6'h00, 2'h2, 1'h0, 12'h00a, 3'h7,
			{1'h1, 12'h001, 3'h0, 3'h0, 3'h0}};
		rows[5] = '{32'h0003_e000, 6'h00, 2'h2, 1'h1, 12'h00a, 3'h4,
			{1'h1, 12'h00a, 3'h4, 3'h0, 3'h0}};
		rows[6] = '{32'h0000_b005, 6'h02, 2'h1, 1'h1, 12'h005, 3'h1,
			{1'h0, 12'h005, 3'h1, 3'h1, 3'h0}};
		repeat (6) @(posedge clock);
		rst_b <= 1'h1;
		// ports 1 and 2 hybrid, port 0 keeps tags
		apb(1'h1, `VTWD_IDX_EGTYPE, 32'h0000_0006);
		for (int i = 0; i < 7; i++) begin
			apb(1'h1, `VTWD_IDX_WDATA, rows[i].wd);
			// data staged before the command; rows 4 and 5 stage vid 0
			apb(1'h1, `VTWD_IDX_CMD, {26'h000_0000, rows[i].cmd});
			apb(1'h0, `VTWD_IDX_STS, 32'h0000_0000);
			chk(rd, 32'h0000_0000);
			chk({31'h0000_0000, er}, 32'h0000_0000);
			send(rows[i].port, rows[i].tg, rows[i].vid, rows[i].pri);
			chk(cls(), {10'h000, rows[i].exp});
		end
		apb(1'h1, `VTWD_IDX_ADMIT, 32'h0000_0001);
		send(2'h0, 1'h1, 12'h0fe, 3'h1);
		chk(cls(), {10'h000, 1'h0, 12'h0fe, 3'h1, 3'h6, 3'h2});
		apb(1'h1, `VTWD_IDX_CTRL, 32'h0000_0001);
		send(2'h1, 1'h1, 12'h0fe, 3'h6);
		chk(cls(), {10'h000, 1'h0, 12'h001, 3'h0, 3'h5, 3'h0});
		apb(1'h1, `VTWD_IDX_CTRL, 32'h0000_0000);
		apb(1'h1, `VTWD_IDX_CMD, 32'h0000_0030);
		apb(1'h0, `VTWD_IDX_RDATA, 32'h0000_0000);
		chk(rd, 32'h0000_30fe);
		apb(1'h1, `VTWD_IDX_CMD, 32'h0000_0021);
		apb(1'h0, `VTWD_IDX_RDATA, 32'h0000_0000);
		chk(rd, 32'h0002_c0fe);
		apb(1'h1, `VTWD_IDX_WDATA, 32'hffff_ffff);
		apb(1'h0, `VTWD_IDX_WDATA, 32'h0000_0000);
		chk(rd, 32'h0003_ffff);
		apb(1'h0, 14'h1900, 32'h0000_0000);
		chk({31'h0000_0000, er}, 32'h0000_0001);
		// mid-run reset must restore the port defaults
		@(posedge clock);
		rst_b <= 1'h0;
		repeat (6) @(posedge clock);
		rst_b <= 1'h1;
		apb(1'h0, `VTWD_IDX_WDATA, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'h1, `VTWD_IDX_CMD, 32'h0000_0032);
		apb(1'h0, `VTWD_IDX_RDATA, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		summarize();
	end
endmodule // tb_vlan_table_write_data

// file: bench/vtwd_chk.sv
// concurrent checks on the ports of vtwd_top
// assumes one clock domain and synchronous active-low rst_b
`timescale 1ns/100ps
`include "vtwd_consts.vh"

module vtwd_chk #(
	parameter NUM_PORTS = 3,
	parameter VID_W = 12,
	parameter PRI_W = 3
) (
	input wire clock,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire rx_valid,
	input wire [1:0] rx_port,
	input wire rx_tagged,
	input wire [VID_W-1:0] rx_vid,
	input wire [PRI_W-1:0] rx_pri,
	input wire cls_valid,
	input wire cls_drop,
	input wire [VID_W-1:0] cls_vid,
	input wire [PRI_W-1:0] cls_pri,
	input wire [NUM_PORTS-1:0] cls_egress,
	input wire [NUM_PORTS-1:0] cls_untag
);
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	wire [13:0] idx = paddr[15:2];
	wire mapped = (idx >= `VTWD_IDX_CMD && idx <= `VTWD_IDX_RDATA) ||
		(idx >= `VTWD_IDX_CTRL && idx <= `VTWD_IDX_EGTYPE);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence access_s;
		psel && penable && pready;
	endsequence
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	apb_answer_a: assert property (setup_s |=> access_s)
		else $error("no ready in the cycle after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held past one cycle");
	unmapped_err_a: assert property (setup_s ##0 !mapped |=>
		pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	mapped_ok_a: assert property (setup_s ##0 mapped |=> !pslverr)
		else $error("mapped access refused");
	wdata_resv_a: assert property (pready && !pwrite &&
		idx == `VTWD_IDX_WDATA |-> prdata[31:18] == 14'h0000)
		else $error("reserved write data bits read nonzero");
	cls_latency_a: assert property (rx_valid |=> cls_valid)
		else $error("classify result late");
	cls_idle_a: assert property (!rx_valid |=> !cls_valid &&
		$stable(cls_vid) && $stable(cls_egress))
		else $error("classify output moved without a frame");
	drop_clear_a: assert property (cls_drop |->
		cls_egress == 3'h0 && cls_untag == 3'h0)
		else $error("dropped frame still floods");
	no_echo_a: assert property (rx_valid && rx_port != 2'h3 |=>
		!cls_egress[$past(rx_port)])
		else $error("frame flooded back to its ingress port");
	untag_sub_a: assert property (cls_valid |->
		(cls_untag & ~cls_egress) == 3'h0)
		else $error("untag set on a port outside the flood set");
endmodule // vtwd_chk

bind vtwd_top vtwd_chk #(
	.NUM_PORTS(NUM_PORTS),
	.VID_W(VID_W),
	.PRI_W(PRI_W)
) u_chk (
	.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .rx_valid(rx_valid),
	.rx_port(rx_port), .rx_tagged(rx_tagged), .rx_vid(rx_vid),
	.rx_pri(rx_pri), .cls_valid(cls_valid), .cls_drop(cls_drop),
	.cls_vid(cls_vid), .cls_pri(cls_pri), .cls_egress(cls_egress),
	.cls_untag(cls_untag)
);

// file: pkg/vtwd_consts.vh
// constants for the vlan table write-data staging block and its neighbours
// assumes register indices are word numbers; byte address is index * 4
//
// Functional notes
// RULE1: port mode: bits 11:0 vid, 14:12 priority
// RULE2: untagged or null-vid frames get port defaults
// RULE3: vlan disable forces port defaults on frames
// RULE4: reset defaults: vid one, priority zero, all ports
// RULE5: software avoids default vid zero or all ones
// RULE6: bit 17: port 2 admits and floods
// RULE7: non-member drops unless admitted; excluded from flood
// RULE8: bit 16 strips tag on hybrid port 2
// RULE9: bits 15/14: port 1 member and untag
// RULE10: software stages data, writes command, polls pending
// RULE11: table select one: port table; zero: vlan
// RULE12: bits 13/12 port 0; 11:0 entry vid
// RULE13: entry with vid zero is disabled
// RULE14: reserved upper bits read zero, ignore writes
`ifndef VTWD_CONSTS_VH
`define VTWD_CONSTS_VH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define VTWD_IDX_CMD 14'h180B
`define VTWD_IDX_WDATA 14'h180C
`define VTWD_IDX_STS 14'h180D
`define VTWD_IDX_RDATA 14'h180E
`define VTWD_IDX_CTRL 14'h1810
`define VTWD_IDX_ADMIT 14'h1811
`define VTWD_IDX_EGTYPE 14'h1812

// ----------------------------------------------------------------
// command register fields
// ----------------------------------------------------------------
`define VTWD_CMD_RNW 5
`define VTWD_CMD_TSEL 4
`define VTWD_CMD_IDX_HI 3
`define VTWD_CMD_IDX_LO 0
`define VTWD_CMD_WIDTH 6

// ----------------------------------------------------------------
// write data layouts
// ----------------------------------------------------------------
`define VTWD_WDATA_HI 17
`define VTWD_VID_HI 11
`define VTWD_VID_LO 0
`define VTWD_PRI_HI 14
`define VTWD_PRI_LO 12
`define VTWD_ENT_MEM2 17
`define VTWD_ENT_UNT2 16
`define VTWD_ENT_MEM1 15
`define VTWD_ENT_UNT1 14
`define VTWD_ENT_MEM0 13
`define VTWD_ENT_UNT0 12

// ----------------------------------------------------------------
// other fields and reset values
// ----------------------------------------------------------------
`define VTWD_STS_PENDING 0
`define VTWD_CTRL_VDIS 0
`define VTWD_RST_PVID 12'h001
`define VTWD_RST_PRI 3'h0
`define VTWD_NULL_VID 12'h000
`define VTWD_RST_ENTRY 18'h0_0000
`define VTWD_RST_WORD 32'h0000_0000

`endif

// file: verilog/vtwd_top.v
// vlan write-data staging register, vlan and port default tables,
// command engine and ingress classifier, reached over apb
// assumes rx_* come from logic on the same clock, one frame per pulse
`timescale 1ns/100ps
`include "vtwd_consts.vh"

module vtwd_top #(
	parameter NUM_PORTS = 3,
	parameter NUM_VLANS = 16,
	parameter VID_W = 12,
	parameter PRI_W = 3,
	parameter ENTRY_W = 18
) (
	input wire clock,
	input wire rst_b,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [15:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire rx_valid,
	input wire [1:0] rx_port,
	input wire rx_tagged,
	input wire [VID_W-1:0] rx_vid,
	input wire [PRI_W-1:0] rx_pri,
	output reg cls_valid,
	output reg cls_drop,
	output reg [VID_W-1:0] cls_vid,
	output reg [PRI_W-1:0] cls_pri,
	output reg [NUM_PORTS-1:0] cls_egress,
	output reg [NUM_PORTS-1:0] cls_untag
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	reg [`VTWD_CMD_WIDTH-1:0] cmd_q;
	reg [ENTRY_W-1:0] wdata_q;
	reg [31:0] rdata_q;
	reg pending_q;
	reg pending_d;
	reg vdis_q;
	reg [NUM_PORTS-1:0] admit_q;
	reg [NUM_PORTS-1:0] hybrid_q;
	reg [VID_W-1:0] pvid_q [0:NUM_PORTS-1];
	reg [PRI_W-1:0] ppri_q [0:NUM_PORTS-1];
	wire [ENTRY_W*NUM_VLANS-1:0] ent_flat;
	wire [NUM_VLANS-1:0] ent_hit;
	reg [NUM_VLANS-1:0] ent_we;
	wire setup;
	wire access;
	wire wr_access;
	wire [13:0] widx;
	reg mapped;
	reg [31:0] rmux;
	wire cmd_wr;
	wire exec;
	wire exec_rd;
	wire exec_wr;
	wire tsel;
	wire [3:0] cidx;
	reg [ENTRY_W-1:0] sel_ent;
	reg [VID_W-1:0] sel_pvid;
	reg [PRI_W-1:0] sel_ppri;
	reg sel_port_ok;
	reg [VID_W-1:0] look_vid;
	reg [PRI_W-1:0] look_pri;
	reg [VID_W-1:0] port_pvid;
	reg [PRI_W-1:0] port_ppri;
	reg use_tag;
	reg port_ok;
	reg [NUM_PORTS-1:0] port_bit;
	reg hit_any;
	reg [ENTRY_W-1:0] hit_ent;
	reg [NUM_PORTS-1:0] mem_v;
	reg [NUM_PORTS-1:0] unt_v;
	reg drop_d;
	reg [NUM_PORTS-1:0] egress_d;
	reg [NUM_PORTS-1:0] untag_d;
	integer i;
	integer j;
	integer k;
	integer m;
	integer n;
	genvar g;

	// ----------------------------------------------------------------
	// apb slave: one wait-free access phase, answer prepared in setup
	// ----------------------------------------------------------------
	assign setup = psel && !penable;
	assign access = psel && penable && pready;
	assign wr_access = access && pwrite && !pslverr;
	assign widx = paddr[15:2];

	always @* begin
		mapped = 1'b1;
		rmux = `VTWD_RST_WORD;
		case (widx)
		`VTWD_IDX_CMD: begin
			rmux[`VTWD_CMD_WIDTH-1:0] = cmd_q;
		end
		`VTWD_IDX_WDATA: begin
			// only the staged field bits exist [RULE14]
			rmux[ENTRY_W-1:0] = wdata_q;
		end
		`VTWD_IDX_STS: begin
			rmux[`VTWD_STS_PENDING] = pending_q;
		end
		`VTWD_IDX_RDATA: begin
			rmux = rdata_q;
		end
		`VTWD_IDX_CTRL: begin
			rmux[`VTWD_CTRL_VDIS] = vdis_q;
		end
		`VTWD_IDX_ADMIT: begin
			rmux[NUM_PORTS-1:0] = admit_q;
		end
		`VTWD_IDX_EGTYPE: begin
			rmux[NUM_PORTS-1:0] = hybrid_q;
		end
		default: begin
			mapped = 1'b0;
		end
		endcase
	end

	// read data is captured in setup, so it may lag an update that the
	// command engine makes in that very cycle by one access
	always @(posedge clock) begin
		if (!rst_b) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `VTWD_RST_WORD;
		end else begin
			pready <= setup;
			if (setup) begin
				pslverr <= !mapped;
				prdata <= (mapped && !pwrite) ? rmux : `VTWD_RST_WORD;
			end else if (access) begin
				pslverr <= 1'b0;
				prdata <= `VTWD_RST_WORD;
			end
		end
	end

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	assign cmd_wr = wr_access && (widx == `VTWD_IDX_CMD);

	always @(posedge clock) begin
		if (!rst_b) begin
			cmd_q <= {`VTWD_CMD_WIDTH{1'b0}};
			wdata_q <= `VTWD_RST_ENTRY;
			vdis_q <= 1'b0;
			admit_q <= {NUM_PORTS{1'b0}};
			hybrid_q <= {NUM_PORTS{1'b0}};
		end else if (wr_access) begin
			case (widx)
			`VTWD_IDX_CMD: begin
				cmd_q <= pwdata[`VTWD_CMD_WIDTH-1:0];
			end
			`VTWD_IDX_WDATA: begin
				// upper reserved bits are dropped here [RULE14]
				wdata_q <= pwdata[`VTWD_WDATA_HI:0];
			end
			`VTWD_IDX_CTRL: begin
				vdis_q <= pwdata[`VTWD_CTRL_VDIS];
			end
			`VTWD_IDX_ADMIT: begin
				admit_q <= pwdata[NUM_PORTS-1:0];
			end
			`VTWD_IDX_EGTYPE: begin
				hybrid_q <= pwdata[NUM_PORTS-1:0];
			end
			default: begin
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// command engine: a command runs the cycle after it is written
	// ----------------------------------------------------------------
	assign exec = pending_q;
	assign tsel = cmd_q[`VTWD_CMD_TSEL];
	assign cidx = cmd_q[`VTWD_CMD_IDX_HI:`VTWD_CMD_IDX_LO];
	assign exec_rd = exec && cmd_q[`VTWD_CMD_RNW];
	assign exec_wr = exec && !cmd_q[`VTWD_CMD_RNW];

	// a new command landing as the old one completes keeps pending set
	always @* begin
		pending_d = cmd_wr || (pending_q && !exec);
	end

	always @(posedge clock) begin
		if (!rst_b) begin
			pending_q <= 1'b0;
		end else begin
			pending_q <= pending_d;
		end
	end

	// vlan table write strobes [RULE11]
	always @* begin
		for (i = 0; i < NUM_VLANS; i = i + 1) begin
			ent_we[i] = exec_wr && !tsel && (cidx == i[3:0]);
		end
	end

	// selected entries for read-back
	always @* begin
		sel_ent = `VTWD_RST_ENTRY;
		sel_pvid = `VTWD_NULL_VID;
		sel_ppri = `VTWD_RST_PRI;
		sel_port_ok = 1'b0;
		for (j = 0; j < NUM_VLANS; j = j + 1) begin
			if (cidx == j[3:0]) begin
				sel_ent = ent_flat[j*ENTRY_W +: ENTRY_W];
			end
		end
		for (j = 0; j < NUM_PORTS; j = j + 1) begin
			if (cidx == j[3:0]) begin
				sel_pvid = pvid_q[j];
				sel_ppri = ppri_q[j];
				sel_port_ok = 1'b1;
			end
		end
	end

	// port default table; out-of-range port numbers are ignored
	always @(posedge clock) begin
		if (!rst_b) begin
			for (k = 0; k < NUM_PORTS; k = k + 1) begin
				pvid_q[k] <= `VTWD_RST_PVID; // [RULE4]
				ppri_q[k] <= `VTWD_RST_PRI; // [RULE4]
			end
		end else begin
			for (k = 0; k < NUM_PORTS; k = k + 1) begin
				if (exec_wr && tsel && (cidx == k[3:0])) begin
					// other staged bits are not used here [RULE1] [RULE11]
					pvid_q[k] <= wdata_q[`VTWD_VID_HI:`VTWD_VID_LO];
					ppri_q[k] <= wdata_q[`VTWD_PRI_HI:`VTWD_PRI_LO];
				end
			end
		end
	end

	always @(posedge clock) begin
		if (!rst_b) begin
			rdata_q <= `VTWD_RST_WORD;
		end else if (exec_rd) begin
			rdata_q <= `VTWD_RST_WORD;
			if (tsel) begin
				if (sel_port_ok) begin
					rdata_q[`VTWD_VID_HI:`VTWD_VID_LO] <= sel_pvid;
					rdata_q[`VTWD_PRI_HI:`VTWD_PRI_LO] <= sel_ppri;
				end
			end else begin
				rdata_q[ENTRY_W-1:0] <= sel_ent;
			end
		end
	end

	// ----------------------------------------------------------------
	// vlan table
	// ----------------------------------------------------------------
	generate
		for (g = 0; g < NUM_VLANS; g = g + 1) begin : g_ent
			vtwd_vlan_entry #(
				.ENTRY_W(ENTRY_W),
				.VID_W(VID_W)
			) u_ent (
				.clock(clock),
				.rst_b(rst_b),
				.wr_en(ent_we[g]),
				.wr_data(wdata_q),
				.lookup_vid(look_vid),
				.entry_q(ent_flat[g*ENTRY_W +: ENTRY_W]),
				.hit(ent_hit[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// ingress classification
	// ----------------------------------------------------------------
	always @* begin
		port_pvid = `VTWD_RST_PVID;
		port_ppri = `VTWD_RST_PRI;
		port_ok = 1'b0;
		port_bit = {NUM_PORTS{1'b0}};
		for (m = 0; m < NUM_PORTS; m = m + 1) begin
			if (rx_port == m[1:0]) begin
				port_pvid = pvid_q[m];
				port_ppri = ppri_q[m];
				port_ok = 1'b1;
				port_bit[m] = 1'b1;
			end
		end
		// null vid or no tag falls back to port defaults [RULE2]
		// vlan disable also forces the port defaults [RULE3]
		use_tag = rx_tagged && (rx_vid != `VTWD_NULL_VID) && !vdis_q;
		look_vid = use_tag ? rx_vid : port_pvid;
		look_pri = use_tag ? rx_pri : port_ppri;
	end

	// lowest matching entry wins if software programs a vid twice
	always @* begin
		hit_any = 1'b0;
		hit_ent = `VTWD_RST_ENTRY;
		for (n = NUM_VLANS - 1; n >= 0; n = n - 1) begin
			if (ent_hit[n]) begin
				hit_any = 1'b1;
				hit_ent = ent_flat[n*ENTRY_W +: ENTRY_W];
			end
		end
		mem_v = {hit_ent[`VTWD_ENT_MEM2], hit_ent[`VTWD_ENT_MEM1],
			hit_ent[`VTWD_ENT_MEM0]}; // [RULE6] [RULE9] [RULE12]
		unt_v = {hit_ent[`VTWD_ENT_UNT2], hit_ent[`VTWD_ENT_UNT1],
			hit_ent[`VTWD_ENT_UNT0]}; // [RULE8] [RULE9] [RULE12]
	end

	always @* begin
		drop_d = 1'b0;
		egress_d = {NUM_PORTS{1'b0}};
		untag_d = {NUM_PORTS{1'b0}};
		if (!port_ok) begin
			drop_d = 1'b1;
		end else if (vdis_q) begin
			// without vlan filtering every other port is flooded
			egress_d = ~port_bit;
		end else if (!hit_any) begin
			drop_d = 1'b1;
		end else begin
			// non-member ingress drops unless admitted [RULE7]
			drop_d = !(|(mem_v & port_bit)) && !(|(admit_q & port_bit));
			// flood only to member ports [RULE6] [RULE7]
			egress_d = mem_v & ~port_bit;
			// strip only on hybrid egress ports [RULE8]
			untag_d = unt_v & hybrid_q & egress_d;
		end
		if (drop_d) begin
			egress_d = {NUM_PORTS{1'b0}};
			untag_d = {NUM_PORTS{1'b0}};
		end
	end

	always @(posedge clock) begin
		if (!rst_b) begin
			cls_valid <= 1'b0;
			cls_drop <= 1'b0;
			cls_vid <= `VTWD_NULL_VID;
			cls_pri <= `VTWD_RST_PRI;
			cls_egress <= {NUM_PORTS{1'b0}};
			cls_untag <= {NUM_PORTS{1'b0}};
		end else begin
			cls_valid <= rx_valid;
			if (rx_valid) begin
				cls_drop <= drop_d;
				cls_vid <= look_vid;
				cls_pri <= look_pri;
				cls_egress <= egress_d;
				cls_untag <= untag_d;
			end
		end
	end

endmodule // vtwd_top

// file: verilog/vtwd_vlan_entry.v
// one vlan table entry: storage of members, untag bits and vid
// assumes the owner pulses wr_en for one cycle per table write
`timescale 1ns/100ps
`include "vtwd_consts.vh"

module vtwd_vlan_entry #(
	parameter ENTRY_W = 18,
	parameter VID_W = 12
) (
	input wire clock,
	input wire rst_b,
	input wire wr_en,
	input wire [ENTRY_W-1:0] wr_data,
	input wire [VID_W-1:0] lookup_vid,
	output reg [ENTRY_W-1:0] entry_q,
	output wire hit
);

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		if (!rst_b) begin
			entry_q <= `VTWD_RST_ENTRY;
		end else if (wr_en) begin
			entry_q <= wr_data;
		end
	end

	// ----------------------------------------------------------------
	// match
	// ----------------------------------------------------------------
	// a zero vid marks the entry unused, so it never matches [RULE13]
	assign hit = (entry_q[VID_W-1:0] != `VTWD_NULL_VID) &&
		(entry_q[VID_W-1:0] == lookup_vid);

endmodule // vtwd_vlan_entry
